// ---- common/fcs_cfg.svh ----
// Constants of the fieldbus command/state word block: defaults, bit
// positions of both words, widths.
// Assumes the includer has no other macros with the FCS_ prefix.
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

// Word width and default command word
`define FCS_W 16
`define FCS_DEF_CMD 16'h0005
`define FCS_ZERO_WORD 16'h0000

// Command word bit positions
`define FCS_C_SWON 0
`define FCS_C_QSTOP_N 2
`define FCS_C_ACK 7
`define FCS_C_DVALID 10
`define FCS_C_WDOG 11
`define FCS_C_AUX_LO 12
`define FCS_C_AUX_HI 15

// State word bit positions
`define FCS_S_SWON_RDY 0
`define FCS_S_RUN_RDY 1
`define FCS_S_RUNNING 2
`define FCS_S_FAULT 3
`define FCS_S_QSTOP_N 5
`define FCS_S_WARN 7
`define FCS_S_PLC 9
`define FCS_S_RUN_EN 11
`define FCS_S_WDOG 15

`endif

// ---- common/fcs_pkg.sv ----
// Types of the fieldbus command/state word block.
// Assumes fcs_cfg.svh sits on the include path.
`include "fcs_cfg.svh"

package fcs_pkg;

  typedef logic [`FCS_W-1:0] fcs_word_t;

  typedef logic [3:0] fcs_aux_t;

  // Complete state of the block, registered as one vector
  typedef struct packed {
    fcs_word_t held_cmd;
    fcs_word_t held_pd;
    fcs_word_t eff_cmd;
    fcs_word_t pd_out;
    fcs_word_t state_word;
    fcs_aux_t aux;
    logic ack_prev;
    logic ack_req;
  } fcs_state_t;

endpackage

// ---- src/fcs_words.sv ----
// Fieldbus command word interpreter and state word builder.
// Assumes all inputs are synchronous to CLK and that the fieldbus layer
// presents the currently received words as levels.
`timescale 1ns/100ps
`include "fcs_cfg.svh"

module fcs_words (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Received fieldbus words
  input wire fcs_pkg::fcs_word_t CMD_WORD,
  input wire fcs_pkg::fcs_word_t PD_IN,
  input wire logic PROTO_REG,
  // Configuration and supervision
  input wire logic FB_PLACE,
  input wire logic INDEP_RESET_EN,
  input wire logic WDOG_FAULT,
  input wire logic WDOG_AS_FAULT,
  // Converter status
  input wire fcs_pkg::fcs_word_t GRID_READY,
  input wire fcs_pkg::fcs_word_t APP_READY,
  input wire logic MODULATING,
  input wire logic FAULT_ACTIVE,
  input wire logic WARNING_ACTIVE,
  input wire logic RUN_EN_IN,
  input wire logic WDOG_OUT_BIT,
  // Interpreted command
  output fcs_pkg::fcs_word_t EFF_CMD,
  output fcs_pkg::fcs_word_t PD_OUT,
  output logic SWITCH_ON_EN,
  output logic QUICK_STOP_REQ,
  output logic EVENT_RESET_REQ,
  output fcs_pkg::fcs_aux_t AUX_OUT,
  output logic WDOG_IN_BIT,
  // State word back to the master
  output fcs_pkg::fcs_word_t STATE_WORD
);
  import fcs_pkg::*;

  localparam fcs_state_t RST_ST = '{
    held_cmd: `FCS_DEF_CMD,
    held_pd: `FCS_ZERO_WORD,
    eff_cmd: `FCS_DEF_CMD,
    pd_out: `FCS_ZERO_WORD,
    state_word: `FCS_ZERO_WORD,
    aux: 4'h0,
    ack_prev: 1'b0,
    ack_req: 1'b0
  };

  fcs_state_t st_ff;
  fcs_state_t nxt_st;

  // True when every bit of the word is set
  function automatic logic all_set(input fcs_word_t w);
    all_set = &w;
  endfunction

  // Drop the bits the master may not drive from another control place.
  // Dropped bits take their default value, so a foreign place never
  // leaves a stray quick stop behind; the default holds the switch-on enable set.
  function automatic fcs_word_t place_mask(input fcs_word_t w,
                                           input logic fb,
                                           input logic indep);
    fcs_word_t r;
    r = w;
    if (!fb) begin
      r = `FCS_DEF_CMD;
      r[`FCS_C_DVALID] = w[`FCS_C_DVALID];
      r[`FCS_C_WDOG] = w[`FCS_C_WDOG];
      if (indep) begin
        r[`FCS_C_ACK] = w[`FCS_C_ACK];
      end
    end
    place_mask = r;
  endfunction

  logic dvalid;
  logic wdog_sub;
  logic ack_now;
  fcs_word_t sel_cmd;
  fcs_word_t new_eff;
  fcs_word_t sw;

  always_comb begin
    nxt_st = st_ff;
    dvalid = CMD_WORD[`FCS_C_DVALID];
    wdog_sub = WDOG_FAULT & WDOG_AS_FAULT;

    // Command word: freeze on data valid low, default on watchdog fault
    if (dvalid) begin
      nxt_st.held_cmd = CMD_WORD;
    end
    sel_cmd = dvalid ? CMD_WORD : st_ff.held_cmd;
    if (wdog_sub) begin
      sel_cmd = `FCS_DEF_CMD;
    end
    // The toggle must track the wire or the supervision trips itself
    sel_cmd[`FCS_C_WDOG] = CMD_WORD[`FCS_C_WDOG];
    sel_cmd[`FCS_C_DVALID] = dvalid;
    new_eff = place_mask(sel_cmd, FB_PLACE, INDEP_RESET_EN);
    nxt_st.eff_cmd = new_eff;

    // Other process data: gated only outside the register protocol
    if (dvalid && !PROTO_REG) begin
      nxt_st.held_pd = PD_IN;
    end
    if (PROTO_REG || dvalid) begin
      nxt_st.pd_out = PD_IN;
    end else begin
      nxt_st.pd_out = st_ff.held_pd;
    end

    // Auxiliary functions follow the effective command word
    nxt_st.aux = new_eff[`FCS_C_AUX_HI:`FCS_C_AUX_LO];

    // Acknowledge edge, judged on the effective word so a masked bit
    // that later reappears high still counts as a fresh edge
    ack_now = new_eff[`FCS_C_ACK];
    nxt_st.ack_prev = ack_now;
    nxt_st.ack_req = ack_now & ~st_ff.ack_prev;

    // State word, built from the effective command word now registered
    sw = `FCS_ZERO_WORD;
    sw[`FCS_S_SWON_RDY] = st_ff.eff_cmd[`FCS_C_SWON] &
                          st_ff.eff_cmd[`FCS_C_QSTOP_N] &
                          ~FAULT_ACTIVE;
    sw[`FCS_S_RUN_RDY] = all_set(GRID_READY) &
                         all_set(APP_READY);
    sw[`FCS_S_RUNNING] = MODULATING;
    sw[`FCS_S_FAULT] = FAULT_ACTIVE;
    sw[`FCS_S_QSTOP_N] = st_ff.eff_cmd[`FCS_C_QSTOP_N];
    sw[`FCS_S_WARN] = WARNING_ACTIVE;
    sw[`FCS_S_PLC] = FB_PLACE;
    sw[`FCS_S_RUN_EN] = RUN_EN_IN;
    sw[`FCS_S_WDOG] = WDOG_OUT_BIT;
    nxt_st.state_word = sw;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_ff <= RST_ST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign EFF_CMD = st_ff.eff_cmd;
  assign PD_OUT = st_ff.pd_out;
  assign SWITCH_ON_EN = st_ff.eff_cmd[`FCS_C_SWON];
  // Inverted polarity: a low bit asks for the stop
  assign QUICK_STOP_REQ = ~st_ff.eff_cmd[`FCS_C_QSTOP_N];
  assign EVENT_RESET_REQ = st_ff.ack_req;
  assign AUX_OUT = st_ff.aux;
  assign WDOG_IN_BIT = st_ff.eff_cmd[`FCS_C_WDOG];
  assign STATE_WORD = st_ff.state_word;

endmodule

// ---- verif/fcs_words_properties.sv ----
// Port assertions of the command/state word block.
// Assumes a bind into fcs_words with one clock domain.
`timescale 1ns/100ps
module fcs_words_properties (
  input wire logic CLK, NRST, FB_PLACE, MODULATING, FAULT_ACTIVE,
  input wire logic WDOG_OUT_BIT, EVENT_RESET_REQ, WDOG_IN_BIT,
  input wire fcs_pkg::fcs_aux_t AUX_OUT,
  input wire fcs_pkg::fcs_word_t CMD_WORD, GRID_READY, APP_READY,
  input wire fcs_pkg::fcs_word_t EFF_CMD, STATE_WORD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_wdog_live: assert property ($past(NRST) |->
    WDOG_IN_BIT == $past(CMD_WORD[11])) else $error("watchdog bit");
  a_aux_map: assert property (AUX_OUT == EFF_CMD[15:12])
    else $error("aux bits");
  a_ack_edge: assert property ($past(NRST) |->
    EVENT_RESET_REQ == (EFF_CMD[7] > $past(EFF_CMD[7]))) else $error("ack");
  a_place_mask: assert property ($past(NRST) &&
    !$past(FB_PLACE) |-> (EFF_CMD & 16'hf37f) == 16'h0005) else $error("mask");
  a_ready_run: assert property ($past(NRST) |->
    STATE_WORD[1] == &{$past(GRID_READY), $past(APP_READY)})
    else $error("run ready");
  a_state_copy: assert property ($past(NRST) |->
    {STATE_WORD[15], STATE_WORD[3:2]} == {$past(WDOG_OUT_BIT),
    $past(FAULT_ACTIVE), $past(MODULATING)}) else $error("state bits");
  a_swon_rdy: assert property ($past(NRST) |->
    {STATE_WORD[5], STATE_WORD[0]} == {$past(EFF_CMD[2]), $past(EFF_CMD[0])
    && $past(EFF_CMD[2]) && !$past(FAULT_ACTIVE)}) else $error("ready");
  a_rsvd_zero: assert property (!STATE_WORD[4] && !STATE_WORD[6])
    else $error("reserved bits");
  c_ack: cover property (EVENT_RESET_REQ);
  c_mask: cover property (!FB_PLACE ##1 EFF_CMD[7]);
  c_ready: cover property (STATE_WORD[0] && STATE_WORD[1]);
endmodule
bind fcs_words fcs_words_properties u_chk (.*);

// ---- verif/fcs_master.sv ----
// Fieldbus master model: a written command word stays until rewritten.
// Assumes put is called just after a rising clock edge.
`timescale 1ns/100ps
module fcs_master (
  // Command word to the block
  output fcs_pkg::fcs_word_t CMD_WORD = 16'h0000
);
  import fcs_pkg::*;
  task put(input fcs_word_t w);
    CMD_WORD = w;
  endtask
endmodule

// ---- verif/fcs_words_test.sv ----
// Self-checking bench of the command/state word block.
// Assumes the package, checker and master model come first.
`timescale 1ns/100ps
module fcs_words_test;
  import fcs_pkg::*;
  logic CLK = 0, NRST = 0, PROTO_REG = 0, FB_PLACE = 1, INDEP_RESET_EN = 0;
  logic WDOG_FAULT = 0, WDOG_AS_FAULT = 0, MODULATING = 0, FAULT_ACTIVE = 0;
  logic WARNING_ACTIVE = 0, RUN_EN_IN = 0, WDOG_OUT_BIT = 0;
  logic SWITCH_ON_EN, QUICK_STOP_REQ, EVENT_RESET_REQ, WDOG_IN_BIT;
  fcs_word_t CMD_WORD, EFF_CMD, PD_OUT, STATE_WORD, PD_IN = 16'ha5a5;
  fcs_word_t GRID_READY = '1, APP_READY = '1;
  fcs_aux_t AUX_OUT;
  int fail_count = 0, tests_run = 0;
  // Place, own ack, watchdog fault, pulse; command; effective word
  logic [35:0] r [6] = '{{4'h9, 16'hf485, 16'hf485},
    {4'h8, 16'h0800, 16'hf885}, {4'ha, 16'hf4ff, 16'h0405},
    {4'h0, 16'h3c81, 16'h0c05}, {4'h5, 16'h3c81, 16'h0c85},
    {4'h8, 16'h0000, 16'h3081}};
  fcs_master M (.CMD_WORD);
  fcs_words DUT (.*);
  always #2 CLK = ~CLK;
  task chk(input fcs_word_t g, e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task step();
    @(posedge CLK) #1;
  endtask
  task finish_test();
    $display("%0d checks, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #400 fail_count++;
    finish_test();
  end
  initial begin
    repeat (10) step();
    NRST = 1;
    step();
    chk(EFF_CMD, 16'h0005);
    foreach (r[i]) begin
      {FB_PLACE, INDEP_RESET_EN, WDOG_FAULT} = r[i][35:33];
      WDOG_AS_FAULT = r[i][33];
      // Status inputs vary so the state word assertions see both levels
      {MODULATING, FAULT_ACTIVE, WDOG_OUT_BIT} = 3'(i);
      APP_READY[0] = i[0];
      M.put(r[i][31:16]);
      step();
      chk(EFF_CMD, r[i][15:0]);
      chk({14'h0, EVENT_RESET_REQ, QUICK_STOP_REQ},
        {14'h0, r[i][32], !r[i][2]});
    end
    $display("table done");
    PD_IN = 16'h1234;
    step();
    chk(PD_OUT, 16'ha5a5);
    PROTO_REG = 1;
    step();
    chk(PD_OUT, 16'h1234);
    $display("data done");
    // Drive every state word source high except FAULT_ACTIVE, which would clear bit 0, so each other bit is seen set
    WARNING_ACTIVE = 1;
    RUN_EN_IN = 1;
    {MODULATING, FAULT_ACTIVE, WDOG_OUT_BIT} = 3'b101;
    M.put(16'h0405);
    step();
    chk({15'h0, SWITCH_ON_EN}, 16'h0001);
    // Bits 0 and 5 lag one more edge behind the effective word
    step();
    chk(STATE_WORD, 16'h8aa7);
    $display("state done");
    NRST = 0;
    step();
    chk(EFF_CMD, 16'h0005);
    chk(STATE_WORD, 16'h0000);
    NRST = 1;
    step();
    $display("reset done");
    finish_test();
  end
endmodule
